/* File: bench/pmlc_phy_model.sv */
// Purpose: far-side stand-in for the internal PHY control bits and status indications
// Assumes: control bits change on hclk, indications arrive off the clock edge
// Notes:   control bits: 0 speed, 1 duplex, 2 negotiation enable, 3 result speed, 4 result duplex
`timescale 1ns/1ps
`default_nettype none
module pmlc_phy_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [4:0] ctrl_set,
	input  wire logic [5:0] ind_set,
	output logic            phy_ctrl_speed,
	output logic            phy_ctrl_duplex,
	output logic            phy_autoneg_enable,
	output logic            an_speed_100,
	output logic            an_full_duplex,
	output logic [5:0]      ind
);
	logic [4:0] ctrl_reg;

	// PHY control word and negotiation outcome, as software last set them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= 5'h00;
		end else begin
			ctrl_reg <= ctrl_set;
		end
	end
	assign phy_ctrl_speed     = ctrl_reg[0];
	assign phy_ctrl_duplex    = ctrl_reg[1];
	assign phy_autoneg_enable = ctrl_reg[2];
	assign an_speed_100       = ctrl_reg[3];
	assign an_full_duplex     = ctrl_reg[4];
	// Off-edge change so the block's synchroniser is really exercised
	assign #1 ind = ind_set;
endmodule // pmlc_phy_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the PHY mode and LED select control block
// Assumes: zero-wait slave, hready tied to hreadyout
// Notes:   expectations come from a small integer model in the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pmlc_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [4:0]  ctrl_set = 5'h00;
	logic [5:0]  ind_set = 6'h00;
	logic [31:0] hrdata;
	logic [1:0]  hresp;
	logic [5:0]  ind;
	logic        hreadyout, pcs, pcd, pae, ans, anf, sp, fd, am, mf, mc, la, lb;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int unsigned seed = 5;

	always #2 hclk = ~hclk;

	pmlc_phy_model phy (.hclk(hclk), .hresetn(hresetn), .ctrl_set(ctrl_set), .ind_set(ind_set),
		.phy_ctrl_speed(pcs), .phy_ctrl_duplex(pcd), .phy_autoneg_enable(pae),
		.an_speed_100(ans), .an_full_duplex(anf), .ind(ind));
	pmlc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phy_ctrl_speed(pcs),
		.phy_ctrl_duplex(pcd), .phy_autoneg_enable(pae), .an_speed_100(ans),
		.an_full_duplex(anf), .ten_link_ind(ind[IND_TEN_LINK]),
		.full_duplex_ind(ind[IND_FULL_DUP]), .activity_ind(ind[IND_ACTIVITY]),
		.fast_link_ind(ind[IND_FAST_LINK]), .receive_ind(ind[IND_RECEIVE]),
		.transmit_ind(ind[IND_TRANSMIT]), .phy_speed_100(sp), .phy_full_duplex(fd),
		.phy_autoneg_mode(am), .mac_full_duplex(mf), .mac_collision_checks(mc),
		.led_out_a(la), .led_out_b(lb));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic int unsigned xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int led_exp(input int code, input int iv);
		if (code == 0) begin
			return ((iv >> IND_FAST_LINK) | (iv >> IND_TEN_LINK)) & 1;
		end
		if (code == 1) begin
			return 0;
		end
		return (iv >> (code - 2)) & 1;
	endfunction

	task automatic stop_test();
		$display("comparisons %0d, n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One edge at which hready is seen high, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			stop_test();
		end
	endtask

	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		check_word("hresp", 32'h0, {30'h0, hresp});
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic [11:0] ra [4];
		int          ca, cb, mode, mfd, ctl, iv, spe, fde, ame;
		ra = '{{4'h0, MODE_LED_ADDR}, {4'h0, MAC_DUPLEX_ADDR}, {4'h0, STATUS_ADDR}, 12'h034};
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, 12'h02A, 32'h0000_38FC, rd);
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, ra[k], 32'h0, rd);
			check_word("reset or unmapped readback", 32'h0, rd);
		end
		for (int i = 0; i < 64; i++) begin
			ca = i & 7;
			cb = (i >> 3) & 7;
			if (ca == 1) ca = 0;
			if (cb == 1) cb = 0;
			mode = (xorshift() & 32'h3800) | (ca << LED_A_LSB) | (cb << LED_B_LSB);
			mfd = xorshift() & 1;
			ctl = xorshift() & 31;
			iv = xorshift() & 63;
			ctrl_set <= ctl[4:0];
			ind_set <= iv[5:0];
			bus(1'b1, {4'h0, MODE_LED_ADDR}, mode, rd);
			bus(1'b1, {4'h0, MAC_DUPLEX_ADDR}, mfd, rd);
			bus(1'b0, {4'h0, MODE_LED_ADDR}, 32'h0, rd);
			check_word("mode register", mode, rd);
			repeat (10) @(posedge hclk);
			ame = mode[AN_SEL_BIT] & ctl[2];
			if (!mode[AN_SEL_BIT]) begin
				spe = mode[SPEED_BIT];
				fde = mode[DUPLEX_BIT];
			end else if (!ctl[2]) begin
				spe = ctl[0];
				fde = ctl[1];
			end else begin
				spe = ctl[3];
				fde = ctl[4];
			end
			check_bit("phy_speed_100", spe[0], sp);
			check_bit("phy_full_duplex", fde[0], fd);
			check_bit("phy_autoneg_mode", ame[0], am);
			check_bit("mac_collision_checks", !mfd[0], mc);
			check_bit("mac_full_duplex", mfd[0], mf);
			check_bit("led_out_a", led_exp(ca, iv) & 1, la);
			check_bit("led_out_b", led_exp(cb, iv) & 1, lb);
			bus(1'b0, {4'h0, STATUS_ADDR}, 32'h0, rd);
			check_word("status", (iv << 8) | (led_exp(cb, iv) << 4) | (led_exp(ca, iv) << 3)
				| (ame << 2) | (fde << 1) | spe, rd);
		end
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, {4'h0, MODE_LED_ADDR}, 32'h0, rd);
		check_word("mode after reset", 32'h0, rd);
		check_bit("mac_full_duplex", 1'b0, mf);
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		stop_test();
	end
endmodule // tb_top
`default_nettype wire

/* File: logic/pmlc_led_mux.sv */
// Purpose: routes one status indication to an LED pin by select code
// Assumes: indications already synchronised, active high
// Notes:   the reserved code drives the LED off
`timescale 1ns/1ps
`default_nettype none
module pmlc_led_mux (
	input  wire logic                                sel_code,
	input  wire logic [pmlc_pkg::LED_SEL_W-1:0]      led_sel,
	input  wire logic [pmlc_pkg::IND_W-1:0]          ind,
	output logic                                     led
);
	import pmlc_pkg::*;

	always_comb begin
		unique case (pmlc_led_sel_t'(led_sel))
			LED_ANY_LINK:  led = ind[IND_FAST_LINK] | ind[IND_TEN_LINK];
			LED_RESERVED:  led = 1'b0;
			LED_TEN_LINK:  led = ind[IND_TEN_LINK];
			LED_FULL_DUP:  led = ind[IND_FULL_DUP];
			LED_ACTIVITY:  led = ind[IND_ACTIVITY];
			LED_FAST_LINK: led = ind[IND_FAST_LINK];
			LED_RECEIVE:   led = ind[IND_RECEIVE];
			LED_TRANSMIT:  led = ind[IND_TRANSMIT];
		endcase
		led = led & sel_code;
	end
endmodule // pmlc_led_mux
`default_nettype wire

/* File: logic/pmlc_mode_resolve.sv */
// Purpose: picks the PHY's effective speed, duplex and negotiation mode
// Assumes: all inputs on the system clock
// Notes:   purely combinational; the caller registers the results
`timescale 1ns/1ps
`default_nettype none
module pmlc_mode_resolve (
	input  wire logic autoneg_select,
	input  wire logic speed_select,
	input  wire logic duplex_select,
	input  wire logic phy_ctrl_speed,
	input  wire logic phy_ctrl_duplex,
	input  wire logic phy_autoneg_enable,
	input  wire logic an_speed_100,
	input  wire logic an_full_duplex,
	output logic      speed_100,
	output logic      full_duplex,
	output logic      autoneg_mode
);
	import pmlc_pkg::*;

	always_comb begin
		autoneg_mode = autoneg_select & phy_autoneg_enable;
		if (!autoneg_select) begin
			speed_100   = speed_select;
			full_duplex = duplex_select;
		end else if (!phy_autoneg_enable) begin
			speed_100   = phy_ctrl_speed;
			full_duplex = phy_ctrl_duplex;
		end else begin
			// Own bits are ignored once negotiation owns the link
			speed_100   = an_speed_100;
			full_duplex = an_full_duplex;
		end
	end
endmodule // pmlc_mode_resolve
`default_nettype wire

/* File: logic/pmlc_pkg.sv */
// Purpose: constants and types shared by the PHY mode and LED select control logic
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   register indices are word indices; byte address = index * 4
// Function
// - Manual mode: own speed bit picks 100/10
// - Manual mode: own duplex bit picks full/half
// - Auto select set: own speed bit ignored
// - Auto select, PHY enable clear: PHY speed
// - Auto select, PHY enable clear: PHY duplex
// - Autoneg mode only when both enables set
// - LED A routed by 3-bit select code
// - LED B routed by independent select code
// - MAC duplex bit clear means half duplex
package pmlc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [5:0]  MODE_LED_IDX   = 6'h0A;
	localparam logic [5:0]  MAC_DUPLEX_IDX = 6'h0B;
	localparam logic [5:0]  STATUS_IDX     = 6'h0C;
	localparam logic [7:0]  MODE_LED_ADDR  = {MODE_LED_IDX, 2'b00};
	localparam logic [7:0]  MAC_DUPLEX_ADDR = {MAC_DUPLEX_IDX, 2'b00};
	localparam logic [7:0]  STATUS_ADDR    = {STATUS_IDX, 2'b00};

	// ----------------------------------------------------------------
	// Mode and LED control register fields
	// ----------------------------------------------------------------
	localparam int          SPEED_BIT      = 13;
	localparam int          DUPLEX_BIT     = 12;
	localparam int          AN_SEL_BIT     = 11;
	localparam int          LED_A_LSB      = 5;
	localparam int          LED_B_LSB      = 2;
	localparam int          LED_SEL_W      = 3;
	localparam logic [15:0] MODE_LED_RESET = 16'h0000;
	localparam logic [15:0] MODE_LED_WMASK = 16'h38FC;

	// ----------------------------------------------------------------
	// MAC duplex register and status register fields
	// ----------------------------------------------------------------
	localparam int          MAC_FDX_BIT    = 0;
	localparam logic        MAC_FDX_RESET  = 1'b0;
	localparam int          ST_SPEED_BIT   = 0;
	localparam int          ST_DUPLEX_BIT  = 1;
	localparam int          ST_ANMODE_BIT  = 2;
	localparam int          ST_LED_A_BIT   = 3;
	localparam int          ST_LED_B_BIT   = 4;
	localparam int          ST_IND_LSB     = 8;

	// ----------------------------------------------------------------
	// Status indication vector positions
	// ----------------------------------------------------------------
	localparam int          IND_W          = 6;
	localparam int          IND_TEN_LINK   = 0;
	localparam int          IND_FULL_DUP   = 1;
	localparam int          IND_ACTIVITY   = 2;
	localparam int          IND_FAST_LINK  = 3;
	localparam int          IND_RECEIVE    = 4;
	localparam int          IND_TRANSMIT   = 5;

	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [1:0]  HRESP_OKAY     = 2'h0;

	typedef enum logic [LED_SEL_W-1:0] {
		LED_ANY_LINK  = 3'h0,
		LED_RESERVED  = 3'h1,
		LED_TEN_LINK  = 3'h2,
		LED_FULL_DUP  = 3'h3,
		LED_ACTIVITY  = 3'h4,
		LED_FAST_LINK = 3'h5,
		LED_RECEIVE   = 3'h6,
		LED_TRANSMIT  = 3'h7
	} pmlc_led_sel_t;

endpackage

/* File: logic/pmlc_top.sv */
// Purpose: PHY speed/duplex/negotiation control and LED routing behind AHB-Lite
// Assumes: single slave on the bus; PHY control bits and negotiation result
//          come from logic on hclk; LED indications arrive asynchronously
// Notes:   zero wait states; every access answers OKAY
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pmlc_top #(
	parameter int ADDR_W = 12
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [1:0]             hresp,
	output logic [31:0]            hrdata,
	input  wire logic              phy_ctrl_speed,
	input  wire logic              phy_ctrl_duplex,
	input  wire logic              phy_autoneg_enable,
	input  wire logic              an_speed_100,
	input  wire logic              an_full_duplex,
	input  wire logic              ten_link_ind,
	input  wire logic              full_duplex_ind,
	input  wire logic              activity_ind,
	input  wire logic              fast_link_ind,
	input  wire logic              receive_ind,
	input  wire logic              transmit_ind,
	output logic                   phy_speed_100,
	output logic                   phy_full_duplex,
	output logic                   phy_autoneg_mode,
	output logic                   mac_full_duplex,
	output logic                   mac_collision_checks,
	output logic                   led_out_a,
	output logic                   led_out_b
);
	import pmlc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0]      ctrl;
		logic             mac_fdx;
		logic             dp_valid;
		logic             dp_write;
		logic             dp_hit;
		logic [5:0]       dp_idx;
		logic [31:0]      rdata;
		logic [IND_W-1:0] sync1;
		logic [IND_W-1:0] sync2;
		logic [IND_W-1:0] sync3;
		logic [IND_W-1:0] ind;
		logic             speed;
		logic             duplex;
		logic             an_mode;
		logic             led_a;
		logic             led_b;
	} pmlc_top_state_t;

	localparam pmlc_top_state_t STATE_RESET = '{
		ctrl:    MODE_LED_RESET,
		mac_fdx: MAC_FDX_RESET,
		default: '0
	};

	pmlc_top_state_t  state_reg;
	pmlc_top_state_t  state_next;
	logic [IND_W-1:0] ind_pins;
	logic             eff_speed;
	logic             eff_duplex;
	logic             eff_an_mode;
	logic             led_a_next;
	logic             led_b_next;
	logic             addr_take;
	logic             addr_hit;

	assign ind_pins = {transmit_ind, receive_ind, fast_link_ind,
		activity_ind, full_duplex_ind, ten_link_ind};

	// ----------------------------------------------------------------
	// Mode selection and LED routing
	// ----------------------------------------------------------------
	pmlc_mode_resolve u_mode (
		.autoneg_select     (state_reg.ctrl[AN_SEL_BIT]),
		.speed_select       (state_reg.ctrl[SPEED_BIT]),
		.duplex_select      (state_reg.ctrl[DUPLEX_BIT]),
		.phy_ctrl_speed     (phy_ctrl_speed),
		.phy_ctrl_duplex    (phy_ctrl_duplex),
		.phy_autoneg_enable (phy_autoneg_enable),
		.an_speed_100       (an_speed_100),
		.an_full_duplex     (an_full_duplex),
		.speed_100          (eff_speed),
		.full_duplex        (eff_duplex),
		.autoneg_mode       (eff_an_mode)
	);

	pmlc_led_mux u_led_a (
		.sel_code (1'b1),
		.led_sel  (state_reg.ctrl[LED_A_LSB +: LED_SEL_W]),
		.ind      (state_reg.ind),
		.led      (led_a_next)
	);

	pmlc_led_mux u_led_b (
		.sel_code (1'b1),
		.led_sel  (state_reg.ctrl[LED_B_LSB +: LED_SEL_W]),
		.ind      (state_reg.ind),
		.led      (led_b_next)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ || htrans[1]);
	assign addr_hit  = (haddr[ADDR_W-1:8] == '0) && (haddr[1:0] == 2'h0) &&
		(haddr[7:2] == MODE_LED_IDX || haddr[7:2] == MAC_DUPLEX_IDX ||
		haddr[7:2] == STATUS_IDX);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;

		// Data phase: a write lands now; reserved bits are never stored
		if (state_reg.dp_valid && state_reg.dp_write && state_reg.dp_hit) begin
			if (state_reg.dp_idx == MODE_LED_IDX) begin
				state_next.ctrl = hwdata[15:0] & MODE_LED_WMASK;
			end
			if (state_reg.dp_idx == MAC_DUPLEX_IDX) begin
				state_next.mac_fdx = hwdata[MAC_FDX_BIT];
			end
		end

		// Address phase: capture, and prepare read data from post-write
		// values so a read right behind a write sees the new contents
		if (hready) begin
			state_next.dp_valid = addr_take;
			state_next.dp_write = hwrite;
			state_next.dp_hit   = addr_hit;
			state_next.dp_idx   = haddr[7:2];
		end
		state_next.rdata = state_reg.rdata;
		if (addr_take && !hwrite) begin
			state_next.rdata = 32'h0000_0000;
			if (addr_hit) begin
				unique case (haddr[7:2])
					MODE_LED_IDX: state_next.rdata[15:0] = state_next.ctrl;
					MAC_DUPLEX_IDX: state_next.rdata[MAC_FDX_BIT] = state_next.mac_fdx;
					default: begin
						state_next.rdata[ST_SPEED_BIT]  = state_reg.speed;
						state_next.rdata[ST_DUPLEX_BIT] = state_reg.duplex;
						state_next.rdata[ST_ANMODE_BIT] = state_reg.an_mode;
						state_next.rdata[ST_LED_A_BIT]  = state_reg.led_a;
						state_next.rdata[ST_LED_B_BIT]  = state_reg.led_b;
						state_next.rdata[ST_IND_LSB +: IND_W] = state_reg.ind;
					end
				endcase
			end
		end

		// Indications: accepted only when the second and third stage agree
		state_next.sync1 = ind_pins;
		state_next.sync2 = state_reg.sync1;
		state_next.sync3 = state_reg.sync2;
		for (int i = 0; i < IND_W; i++) begin
			if (state_reg.sync2[i] == state_reg.sync3[i]) begin
				state_next.ind[i] = state_reg.sync3[i];
			end
		end

		// Recomputed every cycle, so no reset is needed after a change
		state_next.speed   = eff_speed;
		state_next.duplex  = eff_duplex;
		state_next.an_mode = eff_an_mode;
		state_next.led_a   = led_a_next;
		state_next.led_b   = led_b_next;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hreadyout            = 1'b1;
	assign hresp                = HRESP_OKAY;
	assign hrdata               = state_reg.rdata;
	assign phy_speed_100        = state_reg.speed;
	assign phy_full_duplex      = state_reg.duplex;
	assign phy_autoneg_mode     = state_reg.an_mode;
	assign mac_full_duplex      = state_reg.mac_fdx;
	// Collision and quality checks only make sense in half duplex
	assign mac_collision_checks = ~state_reg.mac_fdx;
	assign led_out_a            = state_reg.led_a;
	assign led_out_b            = state_reg.led_b;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence ctrl_write_s;
		state_reg.dp_valid && state_reg.dp_write && state_reg.dp_hit &&
			state_reg.dp_idx == MODE_LED_IDX;
	endsequence

	sequence mac_write_s;
		state_reg.dp_valid && state_reg.dp_write && state_reg.dp_hit &&
			state_reg.dp_idx == MAC_DUPLEX_IDX;
	endsequence

	speed_manual_a: assert property (!state_reg.ctrl[AN_SEL_BIT] |=>
		phy_speed_100 == $past(state_reg.ctrl[SPEED_BIT]))
		else $error("manual speed not taken from own bit");

	duplex_manual_a: assert property (!state_reg.ctrl[AN_SEL_BIT] |=>
		phy_full_duplex == $past(state_reg.ctrl[DUPLEX_BIT]))
		else $error("manual duplex not taken from own bit");

	speed_negotiated_a: assert property (
		state_reg.ctrl[AN_SEL_BIT] && phy_autoneg_enable |=>
		phy_speed_100 == $past(an_speed_100) && phy_autoneg_mode)
		else $error("negotiated speed not followed");

	speed_phy_reg_a: assert property (
		state_reg.ctrl[AN_SEL_BIT] && !phy_autoneg_enable |=>
		phy_speed_100 == $past(phy_ctrl_speed))
		else $error("speed not taken from PHY control bit");

	duplex_phy_reg_a: assert property (
		state_reg.ctrl[AN_SEL_BIT] && !phy_autoneg_enable |=>
		phy_full_duplex == $past(phy_ctrl_duplex) && !phy_autoneg_mode)
		else $error("duplex not taken from PHY control bit");

	autoneg_mode_a: assert property (
		##1 phy_autoneg_mode == $past(state_reg.ctrl[AN_SEL_BIT] && phy_autoneg_enable))
		else $error("negotiation mode without both enables");

	led_a_fast_a: assert property (
		state_reg.ctrl[LED_A_LSB +: LED_SEL_W] == LED_FAST_LINK |=>
		led_out_a == $past(state_reg.ind[IND_FAST_LINK]))
		else $error("LED A not routed to fast link");

	led_a_reserved_a: assert property (
		state_reg.ctrl[LED_A_LSB +: LED_SEL_W] == LED_RESERVED |=> !led_out_a)
		else $error("LED A lit on reserved code");

	led_b_default_a: assert property (
		state_reg.ctrl[LED_B_LSB +: LED_SEL_W] == LED_ANY_LINK |=>
		led_out_b == $past(state_reg.ind[IND_FAST_LINK] | state_reg.ind[IND_TEN_LINK]))
		else $error("LED B default link routing wrong");

	mac_half_dup_a: assert property (mac_write_s |=>
		mac_full_duplex == $past(hwdata[MAC_FDX_BIT]) &&
		mac_collision_checks == !$past(hwdata[MAC_FDX_BIT]))
		else $error("MAC duplex write not applied");

	ctrl_update_a: assert property (
		ctrl_write_s ##0 !hwdata[AN_SEL_BIT] |-> ##2
		phy_speed_100 == $past(hwdata[SPEED_BIT], 2) &&
		phy_full_duplex == $past(hwdata[DUPLEX_BIT], 2))
		else $error("new manual setting not applied in two cycles");

endmodule // pmlc_top
`default_nettype wire
